// ===== pkg/uel_line_map.vh
`ifndef UEL_LINE_MAP_VH
`define UEL_LINE_MAP_VH

`define UEL_FC_CHAR_RESET 8'h00
`define UEL_WLEN_MASK_5 8'h1F
`define UEL_WLEN_MASK_6 8'h3F
`define UEL_WLEN_MASK_7 8'h7F
`define UEL_WLEN_MASK_8 8'hFF
`define UEL_IR_BASIC_NUM 7'h03
`define UEL_IR_BASIC_SHIFT 4
`define UEL_IR_FAST_SHIFT 2
`define UEL_DIR_IDLE 1'b1
`define UEL_BUF_DEPTH 2
`define UEL_BIT_TICKS 16
`define UEL_FT_RUN 3'h0
`define UEL_FT_P1 3'h1
`define UEL_FT_P2 3'h2
`define UEL_FT_HELD 3'h3
`define UEL_FT_R1 3'h4
`define UEL_FT_R2 3'h5

`endif

// ===== logic/uel_pair_buf.v
`timescale 1ns/1ps
module uel_pair_buf #(
    parameter WIDTH = 9,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Fill side
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output wire in_ready,
    // Drain side
    output wire out_valid,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    assign in_ready = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge ref_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push && !pop)
            begin
                count_q <= count_q + 1'b1;
            end
            else if (pop && !push)
            begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// ===== logic/uel_line_features.v
`timescale 1ns/1ps
`include "uel_line_map.vh"
module uel_line_features #(
    parameter LVL_W = 7
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Control bits from the host register set
    input wire sw_flow_en,
    input wire sw_flow_double,
    input wire ier_pause_irq_en,
    input wire ier_sleep_en,
    input wire efr_special_det,
    input wire extra_feature_ctrl_reg_multidrop,
    input wire extra_feature_ctrl_reg_auto_dir,
    input wire extra_feature_ctrl_reg_dir_invert,
    input wire extra_feature_ctrl_reg_ir_fast,
    input wire mcr_ir_en,
    input wire mcr_loopback,
    input wire [1:0] lcr_word_len,
    input wire [3:0] halt_level,
    input wire [3:0] resume_level,
    input wire rts_n_ctrl,
    // Flow-control character write port
    input wire fc_wr,
    input wire [1:0] fc_sel,
    input wire [7:0] fc_wdata,
    // Host receiver enable in multidrop
    input wire rx_en_set,
    input wire rx_en_clr,
    output wire rx_enabled,
    // Status and events
    input wire isr_no_int,
    input wire [3:0] msr_delta,
    input wire isr_read,
    input wire thr_write,
    output wire pause_flag,
    output wire special_flag,
    output wire pause_irq,
    output wire line_status_evt,
    output wire osc_stop,
    // Characters from the base receiver
    input wire rx_char_valid,
    input wire [7:0] rx_char_data,
    input wire rx_char_parity,
    input wire rx_char_perr,
    output reg rx_char_ready,
    // Host receive buffer side
    input wire [LVL_W-1:0] rx_fifo_level,
    output wire host_rx_valid,
    output wire [7:0] host_rx_char,
    output wire host_rx_tag,
    input wire host_rx_ready,
    // Base transmitter
    output wire tx_hold,
    output wire flow_tx_valid,
    output wire [7:0] flow_tx_char,
    input wire flow_tx_ready,
    input wire tx_data_pending,
    input wire tx_line_busy,
    input wire tx_shift_out,
    input wire tx_bit_start,
    input wire samp_tick,
    input wire [4:0] bit_ticks,
    output wire rx_serial,
    // Pins
    input wire rx_pin,
    input wire [3:0] modem_n_pin,
    output wire tx_pin,
    output wire dir_pin
);
    // Power-up value only: no reset branch touches these
    reg [7:0] pause1_q = `UEL_FC_CHAR_RESET;
    reg [7:0] pause2_q = `UEL_FC_CHAR_RESET;
    reg [7:0] resume1_q = `UEL_FC_CHAR_RESET;
    reg [7:0] resume2_q = `UEL_FC_CHAR_RESET;
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    reg [4:0] sync3_q;
    reg pause_q;
    reg special_q;
    reg rx_en_q;
    reg lsr_evt_q;
    reg pend_q;
    reg [8:0] pend_data_q;
    reg [7:0] pend_cmp_q;
    reg [2:0] ft_state_q;
    reg [7:0] ft_char_q;
    reg sleep_q;
    reg [4:0] enc_cnt_q;
    reg [4:0] dec_cnt_q;
    reg tx_pin_q;
    reg dir_pin_q;
    reg rx_serial_q;
    reg [7:0] wmask;
    reg push_v;
    reg [8:0] push_d;
    reg ev_pause;
    reg ev_resume;
    reg ev_special;
    reg ev_lsr;
    reg pend_set;
    reg pend_clr;
    reg en_set;
    reg en_clr;
    wire buf_in_ready;
    wire [7:0] m_c;
    wire [7:0] m_p1;
    wire [7:0] m_p2;
    wire [7:0] m_r1;
    wire [7:0] m_r2;
    wire pair_pause;
    wire pair_resume;
    wire md_normal;
    wire md_auto;
    wire rx_s;
    wire rx_fall;
    wire rx_rise;
    wire modem_chg;
    wire sleep_ok;
    wire wake;
    wire [6:0] basic_prod;
    wire [4:0] basic_len;
    wire [4:0] fast_len;
    wire [4:0] enc_len;
    wire dir_active;

    always @(posedge ref_clk)
    begin
        if (fc_wr)
        begin
            case (fc_sel)
                2'h0: resume1_q <= fc_wdata;
                2'h1: resume2_q <= fc_wdata;
                2'h2: pause1_q <= fc_wdata;
                default: pause2_q <= fc_wdata;
            endcase
        end
    end

    always @*
    begin
        case (lcr_word_len)
            2'h0: wmask = `UEL_WLEN_MASK_5;
            2'h1: wmask = `UEL_WLEN_MASK_6;
            2'h2: wmask = `UEL_WLEN_MASK_7;
            default: wmask = `UEL_WLEN_MASK_8;
        endcase
    end

    // Word-length masked compares
    assign m_c = rx_char_data & wmask;
    assign m_p1 = pause1_q & wmask;
    assign m_p2 = pause2_q & wmask;
    assign m_r1 = resume1_q & wmask;
    assign m_r2 = resume2_q & wmask;
    assign pair_pause = (pend_cmp_q == m_p1) && (m_c == m_p2);
    assign pair_resume = (pend_cmp_q == m_r1) && (m_c == m_r2);
    assign md_normal = extra_feature_ctrl_reg_multidrop & ~efr_special_det;
    assign md_auto = extra_feature_ctrl_reg_multidrop & efr_special_det;

    // A double-mode first character is parked until its partner arrives,
    // so a lone first character reaches the host only after the next one.
    always @*
    begin
        rx_char_ready = 1'b0;
        push_v = 1'b0;
        push_d = {rx_char_perr, rx_char_data};
        ev_pause = 1'b0;
        ev_resume = 1'b0;
        ev_special = 1'b0;
        ev_lsr = 1'b0;
        pend_set = 1'b0;
        pend_clr = 1'b0;
        en_set = 1'b0;
        en_clr = 1'b0;
        if (rx_char_valid)
        begin
            if (pend_q)
            begin
                if (pair_pause || pair_resume)
                begin
                    rx_char_ready = 1'b1;
                    pend_clr = 1'b1;
                    ev_pause = pair_pause;
                    ev_resume = pair_resume;
                end
                else
                begin
                    push_v = 1'b1;
                    push_d = pend_data_q;
                    pend_clr = buf_in_ready;
                end
            end
            else if (sw_flow_en && sw_flow_double && (m_c == m_p1 || m_c == m_r1))
            begin
                rx_char_ready = 1'b1;
                pend_set = 1'b1;
            end
            else if (sw_flow_en && !sw_flow_double && m_c == m_p1)
            begin
                rx_char_ready = 1'b1;
                ev_pause = 1'b1;
            end
            else if (sw_flow_en && !sw_flow_double && m_c == m_r1)
            begin
                rx_char_ready = 1'b1;
                ev_resume = 1'b1;
            end
            else if (md_auto)
            begin
                if (rx_char_parity)
                begin
                    if (m_c == m_p2)
                    begin
                        push_v = 1'b1;
                        push_d = {rx_char_parity, rx_char_data};
                        rx_char_ready = buf_in_ready;
                        en_set = 1'b1;
                        ev_lsr = 1'b1;
                    end
                    else
                    begin
                        rx_char_ready = 1'b1;
                        en_clr = 1'b1;
                    end
                end
                else
                begin
                    push_v = rx_en_q;
                    rx_char_ready = rx_en_q ? buf_in_ready : 1'b1;
                end
            end
            else if (md_normal)
            begin
                if (rx_char_parity)
                begin
                    push_v = 1'b1;
                    push_d = {1'b1, rx_char_data};
                    rx_char_ready = buf_in_ready;
                    ev_lsr = 1'b1;
                end
                else
                begin
                    push_v = rx_en_q;
                    rx_char_ready = rx_en_q ? buf_in_ready : 1'b1;
                end
            end
            else
            begin
                push_v = 1'b1;
                rx_char_ready = buf_in_ready;
                ev_special = efr_special_det && (m_c == m_p2);
            end
        end
    end

    uel_pair_buf #(
        .WIDTH(9),
        .DEPTH(`UEL_BUF_DEPTH),
        .AW(1)
    ) u_buf (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(push_v),
        .in_data(push_d),
        .in_ready(buf_in_ready),
        .out_valid(host_rx_valid),
        .out_data({host_rx_tag, host_rx_char}),
        .out_ready(host_rx_ready)
    );

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pause_q <= 1'b0;
            special_q <= 1'b0;
            rx_en_q <= 1'b0;
            lsr_evt_q <= 1'b0;
            pend_q <= 1'b0;
            pend_data_q <= 9'h000;
            pend_cmp_q <= 8'h00;
        end
        else
        begin
            if (rx_char_ready && ev_pause)
            begin
                pause_q <= 1'b1;
            end
            else if (rx_char_ready && ev_resume)
            begin
                pause_q <= 1'b0;
            end
            if (rx_char_ready && ev_special)
            begin
                special_q <= 1'b1;
            end
            else if (isr_read)
            begin
                special_q <= 1'b0;
            end
            if (rx_char_ready && en_set)
            begin
                rx_en_q <= 1'b1;
            end
            else if (rx_char_ready && en_clr)
            begin
                rx_en_q <= 1'b0;
            end
            else if (rx_en_set)
            begin
                rx_en_q <= 1'b1;
            end
            else if (rx_en_clr)
            begin
                rx_en_q <= 1'b0;
            end
            lsr_evt_q <= rx_char_ready & ev_lsr;
            if (pend_set)
            begin
                pend_q <= 1'b1;
                pend_data_q <= {rx_char_perr, rx_char_data};
                pend_cmp_q <= m_c;
            end
            else if (pend_clr)
            begin
                pend_q <= 1'b0;
            end
        end
    end

    assign pause_flag = pause_q;
    assign special_flag = special_q;
    assign pause_irq = pause_q & ier_pause_irq_en;
    assign line_status_evt = lsr_evt_q;
    assign rx_enabled = rx_en_q;
    assign tx_hold = pause_q;

    // Outgoing pause and resume characters driven by receive fill level
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ft_state_q <= `UEL_FT_RUN;
            ft_char_q <= 8'h00;
        end
        else
        begin
            case (ft_state_q)
                `UEL_FT_RUN:
                begin
                    if (sw_flow_en && rx_fifo_level >= {{(LVL_W-4){1'b0}}, halt_level})
                    begin
                        ft_state_q <= `UEL_FT_P1;
                        ft_char_q <= pause1_q;
                    end
                end
                `UEL_FT_P1:
                begin
                    if (flow_tx_ready)
                    begin
                        ft_state_q <= sw_flow_double ? `UEL_FT_P2 : `UEL_FT_HELD;
                        ft_char_q <= pause2_q;
                    end
                end
                `UEL_FT_P2:
                begin
                    if (flow_tx_ready)
                    begin
                        ft_state_q <= `UEL_FT_HELD;
                    end
                end
                `UEL_FT_HELD:
                begin
                    if (rx_fifo_level <= {{(LVL_W-4){1'b0}}, resume_level})
                    begin
                        ft_state_q <= `UEL_FT_R1;
                        ft_char_q <= resume1_q;
                    end
                end
                `UEL_FT_R1:
                begin
                    if (flow_tx_ready)
                    begin
                        ft_state_q <= sw_flow_double ? `UEL_FT_R2 : `UEL_FT_RUN;
                        ft_char_q <= resume2_q;
                    end
                end
                `UEL_FT_R2:
                begin
                    if (flow_tx_ready)
                    begin
                        ft_state_q <= `UEL_FT_RUN;
                    end
                end
                default:
                begin
                    ft_state_q <= `UEL_FT_RUN;
                end
            endcase
        end
    end

    assign flow_tx_valid = (ft_state_q == `UEL_FT_P1) || (ft_state_q == `UEL_FT_P2) ||
        (ft_state_q == `UEL_FT_R1) || (ft_state_q == `UEL_FT_R2);
    assign flow_tx_char = ft_char_q;

    // Pin synchronisers: bit 4 is the serial input, 3:0 the modem inputs
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sync1_q <= 5'h1F;
            sync2_q <= 5'h1F;
            sync3_q <= 5'h1F;
        end
        else
        begin
            sync1_q <= {rx_pin, modem_n_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign rx_s = sync2_q[4];
    assign rx_fall = sync3_q[4] & ~sync2_q[4];
    assign rx_rise = ~sync3_q[4] & sync2_q[4];
    assign modem_chg = ~mcr_loopback & (sync3_q[3:0] != sync2_q[3:0]);
    assign sleep_ok = isr_no_int & ier_sleep_en & (msr_delta == 4'h0) & rx_s;
    assign wake = rx_fall | thr_write | modem_chg;

    // Re-entry needs the same conditions, so a pending interrupt or an unread
    // modem change keeps the oscillator running
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sleep_q <= 1'b0;
        end
        else if (wake || !sleep_ok)
        begin
            sleep_q <= 1'b0;
        end
        else
        begin
            sleep_q <= 1'b1;
        end
    end

    assign osc_stop = sleep_q;

    // Pulse lengths in sample ticks, never below one tick
    assign basic_prod = {2'b00, bit_ticks} * `UEL_IR_BASIC_NUM;
    assign basic_len = (basic_prod[6:4] == 3'h0) ? 5'h01 : {2'b00, basic_prod[6:4]};
    assign fast_len = (bit_ticks[4:2] == 3'h0) ? 5'h01 : {2'b00, bit_ticks[4:2]};
    assign enc_len = extra_feature_ctrl_reg_ir_fast ? fast_len : basic_len;

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            enc_cnt_q <= 5'h00;
            dec_cnt_q <= 5'h00;
        end
        else
        begin
            if (tx_bit_start && !tx_shift_out)
            begin
                enc_cnt_q <= enc_len;
            end
            else if (samp_tick && enc_cnt_q != 5'h00)
            begin
                enc_cnt_q <= enc_cnt_q - 5'h01;
            end
            if (rx_rise)
            begin
                dec_cnt_q <= bit_ticks;
            end
            else if (samp_tick && dec_cnt_q != 5'h00)
            begin
                dec_cnt_q <= dec_cnt_q - 5'h01;
            end
        end
    end

    assign dir_active = tx_data_pending | tx_line_busy;

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            tx_pin_q <= 1'b1;
            dir_pin_q <= `UEL_DIR_IDLE;
            rx_serial_q <= 1'b1;
        end
        else
        begin
            if (!mcr_loopback)
            begin
                tx_pin_q <= mcr_ir_en ? (enc_cnt_q != 5'h00) : tx_shift_out;
                if (extra_feature_ctrl_reg_auto_dir)
                begin
                    dir_pin_q <= (dir_active ? ~`UEL_DIR_IDLE : `UEL_DIR_IDLE) ^ extra_feature_ctrl_reg_dir_invert;
                end
                else
                begin
                    dir_pin_q <= rts_n_ctrl ^ extra_feature_ctrl_reg_dir_invert;
                end
            end
            if (mcr_loopback)
            begin
                rx_serial_q <= tx_shift_out;
            end
            else if (mcr_ir_en)
            begin
                rx_serial_q <= rx_s | (dec_cnt_q != 5'h00);
            end
            else
            begin
                rx_serial_q <= rx_s;
            end
        end
    end

    assign tx_pin = tx_pin_q;
    assign dir_pin = dir_pin_q;
    assign rx_serial = rx_serial_q;
endmodule

// ===== sim/uel_line_assertions.sv
`timescale 1ns/1ps
module uel_line_assertions (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Controls
    input wire ier_pause_irq_en,
    input wire ier_sleep_en,
    input wire extra_feature_ctrl_reg_auto_dir,
    input wire extra_feature_ctrl_reg_dir_invert,
    input wire mcr_loopback,
    // Status and events
    input wire isr_no_int,
    input wire [3:0] msr_delta,
    input wire thr_write,
    input wire pause_flag,
    input wire pause_irq,
    input wire osc_stop,
    input wire tx_hold,
    // Streams
    input wire rx_char_valid,
    input wire host_rx_valid,
    input wire host_rx_ready,
    input wire [7:0] host_rx_char,
    input wire host_rx_tag,
    input wire flow_tx_valid,
    input wire flow_tx_ready,
    input wire [7:0] flow_tx_char,
    // Transmitter and pins
    input wire tx_data_pending,
    input wire tx_line_busy,
    input wire dir_pin
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_pause_irq: assert property (pause_irq == (pause_flag && ier_pause_irq_en))
        else $error("pause irq not gated by enable");
    a_hold_follows: assert property ($rose(pause_flag) |-> ##[0:1] tx_hold)
        else $error("transmit not held after pause");
    a_dir_drive: assert property (extra_feature_ctrl_reg_auto_dir && !mcr_loopback |=> dir_pin ==
        ($past(tx_data_pending || tx_line_busy) ^ !$past(extra_feature_ctrl_reg_dir_invert)))
        else $error("direction pin wrong");
    a_flow_stand: assert property (flow_tx_valid && !flow_tx_ready |=>
        flow_tx_valid && $stable(flow_tx_char))
        else $error("flow char dropped before taken");
    a_host_stand: assert property (host_rx_valid && !host_rx_ready |=>
        host_rx_valid && $stable({host_rx_tag, host_rx_char}))
        else $error("host char changed while stalled");
    a_sleep_block: assert property (!isr_no_int || !ier_sleep_en || msr_delta != 4'h0
        |=> !osc_stop)
        else $error("sleep while blocked");
    a_wake_write: assert property (thr_write |=> !osc_stop)
        else $error("no wake on transmit write");
    a_push_cause: assert property ($rose(host_rx_valid) |-> $past(rx_char_valid))
        else $error("host char without received char");
endmodule

bind uel_line_features uel_line_assertions i_uel_line_assertions (.*);

// ===== sim/uel_far_end.sv
`timescale 1ns/1ps
module uel_far_end (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Stall request
    input wire stall,
    // Sinks
    input wire flow_tx_valid,
    output wire host_rx_ready,
    output wire flow_tx_ready
);
    logic wait_q = 1'b0;
    // Host side may stall at will, so a full buffer must refuse
    assign host_rx_ready = rst_n && !stall;
    // Slow taker: one wait cycle per flow char proves the char stands
    assign flow_tx_ready = rst_n && !stall && wait_q;
    always @(posedge ref_clk)
        wait_q <= flow_tx_valid && !wait_q;
endmodule

// ===== sim/uel_line_features_test.sv
`timescale 1ns/1ps
module uel_line_features_test;
    logic ref_clk = 0, rst_n = 0, sw_flow_en = 0, sw_flow_double = 0, ier_pause_irq_en = 1;
    logic ier_sleep_en = 0, efr_special_det = 0, extra_feature_ctrl_reg_multidrop = 0, extra_feature_ctrl_reg_auto_dir = 0;
    logic extra_feature_ctrl_reg_dir_invert = 0, extra_feature_ctrl_reg_ir_fast = 0, mcr_ir_en = 0, mcr_loopback = 0;
    logic rts_n_ctrl = 1, fc_wr = 0, rx_en_set = 0, rx_en_clr = 0, isr_no_int = 0;
    logic isr_read = 0, thr_write = 0, rx_char_valid = 0, rx_char_parity = 0;
    logic rx_char_perr = 0, tx_data_pending = 0, tx_line_busy = 0, tx_shift_out = 1;
    logic tx_bit_start = 0, samp_tick = 1, rx_pin = 1, stall = 0, st = 0;
    logic [1:0] lcr_word_len = 2'h3, fc_sel = 2'h0;
    logic [3:0] halt_level = 4'hF, resume_level = 4'h0, msr_delta = 4'h0;
    logic [3:0] modem_n_pin = 4'hF;
    logic [7:0] fc_wdata = 8'h00, rx_char_data = 8'h00;
    logic [6:0] rx_fifo_level = 7'h00;
    logic [4:0] bit_ticks = 5'h10;
    logic [31:0] rs = 32'hCDB4A838;
    logic [8:0] expq[$];
    wire rx_enabled, pause_flag, special_flag, pause_irq, line_status_evt, osc_stop;
    wire rx_char_ready, host_rx_valid, host_rx_tag, host_rx_ready, tx_hold;
    wire flow_tx_valid, flow_tx_ready, rx_serial, tx_pin, dir_pin;
    wire [7:0] host_rx_char, flow_tx_char;
    int fail_count = 0, comparisons = 0, cyc = 0, n, k;

    uel_line_features i_uel_line_features (.*);
    uel_far_end i_uel_far_end (.ref_clk, .rst_n, .stall, .flow_tx_valid, .host_rx_ready,
        .flow_tx_ready);

    always #50 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] s);
        comparisons++;
        if (e !== s)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic cb(input string nm, input logic e, input logic s);
        chk(nm, {8'h00, e}, {8'h00, s});
    endtask

    // Char stays offered until the edge that samples ready high
    task automatic put(input logic [7:0] d, input logic p, input logic e);
        @(negedge ref_clk);
        rs = xs(rs);
        rx_char_valid = 1;
        rx_char_data = d;
        rx_char_parity = p;
        rx_char_perr = rs[3] & ~extra_feature_ctrl_reg_multidrop;
        if (st)
            stall = rs[0];
        // Ready is judged settled before the taking edge; a stall lasts one cycle
        for (n = 0; n < 40; n++)
        begin
            #1;
            if (rx_char_ready === 1'b1)
                break;
            @(negedge ref_clk);
            stall = 0;
        end
        @(posedge ref_clk);
        if (e)
            expq.push_back(extra_feature_ctrl_reg_multidrop ? {p, d} : {rx_char_perr, d});
    endtask

    task automatic idle(input int c);
        @(negedge ref_clk);
        rx_char_valid = 0;
        st = 0;
        stall = 0;
        repeat (c) @(negedge ref_clk);
    endtask

    task automatic fcw(input logic [1:0] s, input logic [7:0] d);
        @(negedge ref_clk);
        fc_wr = 1;
        fc_sel = s;
        fc_wdata = d;
        @(negedge ref_clk);
        fc_wr = 0;
    endtask

    task automatic wflow(input logic [7:0] c);
        for (n = 0; n < 20 && flow_tx_valid !== 1'b1; n++)
            @(negedge ref_clk);
        chk("flow char", {1'b0, c}, {1'b0, flow_tx_char});
        for (n = 0; n < 20 && flow_tx_valid === 1'b1; n++)
            @(negedge ref_clk);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge ref_clk)
        if (rst_n && host_rx_valid && host_rx_ready)
            chk("host char", expq.size() ? expq.pop_front() : 9'h1FF,
                {host_rx_tag, host_rx_char});

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            print_verdict;
        end
    end

    initial
    begin
        repeat (16) @(negedge ref_clk);
        rst_n = 1;
        stall = 1;
        put(8'hA1, 0, 1);
        put(8'hA2, 0, 1);
        @(negedge ref_clk);
        rx_char_data = 8'hA3;
        #10 cb("ready full", 0, rx_char_ready);
        stall = 0;
        put(8'hA3, 0, 1);
        st = 1;
        repeat (12)
        begin
            rs = xs(rs);
            put(rs[15:8], 0, 1);
        end
        idle(8);
        $display("buffer test done");
        sw_flow_en = 1;
        put(8'h00, 0, 0);
        idle(2);
        cb("pause flag", 1, pause_flag);
        fcw(2'h2, 8'h13);
        fcw(2'h0, 8'h11);
        rst_n = 0;
        idle(3);
        rst_n = 1;
        put(8'h13, 0, 0);
        put(8'h41, 0, 1);
        idle(2);
        cb("pause flag", 1, pause_flag);
        cb("pause irq", 1, pause_irq);
        cb("tx hold", 1, tx_hold);
        put(8'h11, 0, 0);
        idle(2);
        cb("pause flag", 0, pause_flag);
        $display("pause test done");
        sw_flow_en = 0;
        efr_special_det = 1;
        lcr_word_len = 2'h0;
        fcw(2'h3, 8'h1A);
        put(8'hFA, 0, 1);
        idle(2);
        cb("special flag", 1, special_flag);
        isr_read = 1;
        idle(1);
        isr_read = 0;
        put(8'h1B, 0, 1);
        idle(2);
        cb("special flag", 0, special_flag);
        $display("special test done");
        lcr_word_len = 2'h3;
        fcw(2'h3, 8'h5A);
        extra_feature_ctrl_reg_multidrop = 1;
        put(8'h22, 0, 0);
        put(8'h33, 1, 0);
        put(8'h5A, 1, 1);
        put(8'h22, 0, 1);
        idle(1);
        cb("rx enabled", 1, rx_enabled);
        put(8'h33, 1, 0);
        put(8'h22, 0, 0);
        idle(1);
        cb("rx enabled", 0, rx_enabled);
        efr_special_det = 0;
        put(8'h44, 0, 0);
        put(8'h45, 1, 1);
        rx_en_set = 1;
        idle(0);
        rx_en_set = 0;
        put(8'h46, 0, 1);
        rx_en_clr = 1;
        idle(0);
        rx_en_clr = 0;
        put(8'h47, 0, 0);
        idle(4);
        extra_feature_ctrl_reg_multidrop = 0;
        $display("multidrop test done");
        sw_flow_en = 1;
        halt_level = 4'h4;
        resume_level = 4'h1;
        rx_fifo_level = 7'h04;
        wflow(8'h13);
        rx_fifo_level = 7'h01;
        wflow(8'h11);
        sw_flow_en = 0;
        $display("flow out test done");
        extra_feature_ctrl_reg_auto_dir = 1;
        for (int i = 0; i < 8; i++)
        begin
            {extra_feature_ctrl_reg_dir_invert, tx_line_busy, tx_data_pending} = i[2:0];
            idle(2);
            cb("dir pin", i[2] ^ ~(i[1] | i[0]), dir_pin);
        end
        $display("direction test done");
        isr_no_int = 1;
        ier_sleep_en = 1;
        idle(6);
        cb("osc stop", 1, osc_stop);
        thr_write = 1;
        @(negedge ref_clk);
        thr_write = 0;
        cb("osc stop", 0, osc_stop);
        msr_delta = 4'h1;
        idle(3);
        cb("osc stop", 0, osc_stop);
        msr_delta = 4'h0;
        idle(4);
        cb("osc stop", 1, osc_stop);
        ier_sleep_en = 0;
        idle(2);
        cb("osc stop", 0, osc_stop);
        $display("sleep test done");
        mcr_ir_en = 1;
        for (int f = 0; f < 2; f++)
        begin
            extra_feature_ctrl_reg_ir_fast = f[0];
            bit_ticks = f ? 5'h08 : 5'h10;
            idle(20);
            cb("ir idle", 0, tx_pin);
            tx_shift_out = 0;
            tx_bit_start = 1;
            @(negedge ref_clk);
            tx_bit_start = 0;
            k = 0;
            repeat (20) @(negedge ref_clk) k += tx_pin;
            chk("ir pulse", f ? 9'h002 : 9'h003, k[8:0]);
        end
        $display("infrared test done");
        mcr_loopback = 1;
        idle(2);
        cb("loopback", tx_shift_out, rx_serial);
        print_verdict;
    end
endmodule
